// ===== bench/pdt_chk.sv
// Purpose: Port checker for the down timer.
// Assumes: Read data registered at the read edge.
// Notes: Timing of the count is left to the bench.
module pdt_chk #(parameter CNT_W = 13) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire terminal_count_out_o
);
  wire [7:0] a = reg_addr_i;
  wire [7:0] q = reg_rdata_o;
  wire tc = terminal_count_out_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence wr_rd(ad);
    reg_wr_i && a == ad ##1 reg_rd_i && a == ad;
  endsequence
  a_reset_quiet: assert property ($fell(rst_i) |-> !tc && q == 8'h00)
    else $error("outputs busy after reset");
  a_unmapped_zero: assert property (reg_rd_i && (a < 8'hB0 || a > 8'hB2) |=> q == 8'h00)
    else $error("unmapped read not zero");
  a_cfg_rsvd: assert property (reg_rd_i && a == 8'hB0 |=> q[7:2] == 6'h00)
    else $error("config reserved bits set");
  a_high_rdbk: assert property (wr_rd(8'hB1) |=> q == {3'h0, $past(reg_wdata_i[4:0], 2)})
    else $error("high count readback");
  a_low_rdbk: assert property (wr_rd(8'hB2) |=> q == $past(reg_wdata_i, 2))
    else $error("low count readback");
  a_cfg_rdbk: assert property (wr_rd(8'hB0) |=> q[1:0] == $past(reg_wdata_i[1:0], 2))
    else $error("config readback");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(q))
    else $error("read data moved");
  a_stop_quiet: assert property (reg_wr_i && a == 8'hB0 && !reg_wdata_i[0] |=> !tc)
    else $error("pulse after stop");
endmodule // pdt_chk

bind pdt_timer pdt_chk #(.CNT_W(CNT_W)) chk_u (.*);

// ===== bench/tb_pdt_timer.sv
// Purpose: Self-checking bench for the down timer.
// Assumes: Inputs change at the falling edge.
// Notes: Counts kept near 260, plus one zero count, so the run stays short.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module tb_pdt_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  wire [7:0] reg_rdata_o;
  wire terminal_count_out_o;
  int mismatches = 0, comparisons = 0, n;
  pdt_timer dut_u (.*);
  initial forever #50 clk_sys_i = ~clk_sys_i;
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic acc(input bit w, input [7:0] ad, d);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {w, !w, ad, d};
    @(negedge clk_sys_i);
    {reg_wr_i, reg_rd_i} = 2'b00;
  endtask
  task automatic rd(input [7:0] ad, e);
    acc(0, ad, 8'h00);
    `CHK(reg_rdata_o, e)
  endtask
  // Counts falling edges until the next pulse; a missing pulse ends the run.
  task automatic tcw(input int e);
    n = 0;
    do begin @(negedge clk_sys_i); n++; end
    while (terminal_count_out_o !== 1'b1 && n < e + 4);
    `CHK(n, e)
    if (terminal_count_out_o !== 1'b1) conclude();
  endtask
  task automatic quiet(input int k);
    repeat (k) begin @(negedge clk_sys_i); `CHK(terminal_count_out_o, 1'b0) end
  endtask
  initial begin
    repeat (16) @(negedge clk_sys_i);
    rst_i = 0;
    @(negedge clk_sys_i);
    rd(8'hB0, 8'h00);
    rd(8'hB2, 8'h00);
    rd(8'hB7, 8'h00);
    acc(1, 8'hB1, 8'h01);
    rd(8'hB1, 8'h01);
    acc(1, 8'hB2, 8'h05);
    rd(8'hB2, 8'h05);
    acc(1, 8'hB0, 8'h01);
    tcw(262);
    tcw(262);
    quiet(1);
    acc(1, 8'hB2, 8'h09);
    tcw(260);
    tcw(266);
    acc(1, 8'hB0, 8'h00);
    quiet(300);
    acc(1, 8'hB0, 8'h03);
    rd(8'hB0, 8'h03);
    tcw(265);
    rd(8'hB0, 8'h02);
    quiet(300);
    acc(1, 8'hB0, 8'h03);
    tcw(266);
    acc(1, 8'hB1, 8'h00);
    acc(1, 8'hB2, 8'h00);
    acc(1, 8'hB0, 8'h01);
    tcw(1);
    @(negedge clk_sys_i); `CHK(terminal_count_out_o, 1'b1)
    acc(1, 8'hB0, 8'h00);
    quiet(2);
    conclude();
  end
endmodule // tb_pdt_timer

// ===== src/pdt_regs.vh
// Purpose: Register map and field constants for the programmable down timer.
// Assumes: Eight-bit register port with an eight-bit address.
// Notes:   Included by the timer core only.
`ifndef PDT_REGS_VH
`define PDT_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDT_ADDR_CONFIG 8'hB0
`define PDT_ADDR_CNT_HIGH 8'hB1
`define PDT_ADDR_CNT_LOW 8'hB2

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PDT_CFG_START_BIT 0
`define PDT_CFG_ONESHOT_BIT 1
`define PDT_CNT_WIDTH 13
`define PDT_HIGH_BITS 5
`define PDT_RST_CONFIG 2'h0
`define PDT_RST_CNT_HIGH 5'h00
`define PDT_RST_CNT_LOW 8'h00

`endif

// ===== src/pdt_timer.v
// Purpose: Thirteen-bit programmable down timer with terminal count pulse.
// Assumes: Register port is synchronous to clk_sys_i; one timer clock per edge.
// Notes:   Terminal count output is registered; reserved bits read as zero.
//
// How it works
// - Thirteen-bit counter decrements each clock and drives a terminal count output.
// - Setting start bit 0 of the config register begins counting.
// - Each start first loads the count from both data registers, then counts down.
// - Counter decrements until zero, ending one full count cycle.
// - At terminal count the output is high for one clock; with a zero count and one-shot clear it stays high.
// - Output low for loaded count clocks; period is count plus one.
// - One-shot bit 1 set: run one cycle, stop, clear start bit.
// - One-shot clear: reload from data registers each cycle and repeat.
// - Setting start again after a one-shot restarts from a fresh full count.
// - High data register holds count bits 12 to 8 in bits 4 to 0.
// - Low data register holds count bits 7 to 0.
`include "pdt_regs.vh"

module pdt_timer #(
  parameter CNT_W = `PDT_CNT_WIDTH
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  // Timer output
  output wire terminal_count_out_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg start_ff;
  reg oneshot_ff;
  reg [4:0] cnt_high_ff;
  reg [7:0] cnt_low_ff;
  reg [CNT_W-1:0] count_ff;
  reg loaded_ff;
  reg tc_ff;
  reg [7:0] rdata_ff;

  reg nxt_start;
  reg [CNT_W-1:0] nxt_count;
  reg nxt_loaded;
  reg nxt_tc;
  reg [7:0] nxt_rdata;

  wire [CNT_W-1:0] full_count;
  wire wr_cfg;
  wire wr_start;

  // Upper data bits.
  // Lower data bits.
  assign full_count = {cnt_high_ff, cnt_low_ff};
  assign wr_cfg = reg_wr_i && (reg_addr_i == `PDT_ADDR_CONFIG);
  assign wr_start = wr_cfg && reg_wdata_i[`PDT_CFG_START_BIT];

  // ----------------------------------------
  // Count engine
  // ----------------------------------------
  always @* begin
    nxt_start = start_ff;
    nxt_count = count_ff;
    nxt_loaded = loaded_ff;
    nxt_tc = 1'b0;
    if (!start_ff) begin
      // Halt while stopped.
      nxt_loaded = 1'b0;
    end else if (!loaded_ff) begin
      // Load on start.
      nxt_count = full_count;
      nxt_loaded = 1'b1;
      nxt_tc = (full_count == {CNT_W{1'b0}});
      if (nxt_tc && oneshot_ff) begin
        nxt_start = 1'b0;
        nxt_loaded = 1'b0;
      end
    end else if (count_ff == {CNT_W{1'b0}}) begin
      // Reload and repeat.
      nxt_count = full_count;
      nxt_tc = (full_count == {CNT_W{1'b0}});
      if (nxt_tc && oneshot_ff) begin
        nxt_start = 1'b0;
        nxt_loaded = 1'b0;
      end
    end else begin
      // Decrement per clock.
      // Run down to zero.
      nxt_count = count_ff - {{(CNT_W-1){1'b0}}, 1'b1};
      // One-clock terminal pulse.
      // Low for count clocks.
      nxt_tc = (nxt_count == {CNT_W{1'b0}});
      if (nxt_tc && oneshot_ff) begin
        // One-shot self clear.
        nxt_start = 1'b0;
        nxt_loaded = 1'b0;
      end
    end
    // Software start wins over self clear.
    // Restart reloads fully.
    if (wr_cfg) begin
      nxt_start = reg_wdata_i[`PDT_CFG_START_BIT];
      // A stop write suppresses any pulse due on the same edge.
      if (!reg_wdata_i[`PDT_CFG_START_BIT]) begin
        nxt_tc = 1'b0;
      end
      if (wr_start && !start_ff) begin
        nxt_loaded = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `PDT_ADDR_CONFIG: nxt_rdata = {6'h00, oneshot_ff, start_ff};
        `PDT_ADDR_CNT_HIGH: nxt_rdata = {3'h0, cnt_high_ff};
        `PDT_ADDR_CNT_LOW: nxt_rdata = cnt_low_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // State update
  // ----------------------------------------
  // Reserved bits are dropped on write, so the obligation cannot corrupt state.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      start_ff <= 1'b0;
      oneshot_ff <= 1'b0;
      cnt_high_ff <= `PDT_RST_CNT_HIGH;
      cnt_low_ff <= `PDT_RST_CNT_LOW;
      count_ff <= {CNT_W{1'b0}};
      loaded_ff <= 1'b0;
      tc_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      start_ff <= nxt_start;
      count_ff <= nxt_count;
      loaded_ff <= nxt_loaded;
      tc_ff <= nxt_tc;
      rdata_ff <= nxt_rdata;
      if (wr_cfg) begin
        oneshot_ff <= reg_wdata_i[`PDT_CFG_ONESHOT_BIT];
      end
      if (reg_wr_i && (reg_addr_i == `PDT_ADDR_CNT_HIGH)) begin
        cnt_high_ff <= reg_wdata_i[4:0];
      end
      if (reg_wr_i && (reg_addr_i == `PDT_ADDR_CNT_LOW)) begin
        cnt_low_ff <= reg_wdata_i;
      end
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign terminal_count_out_o = tc_ff;

endmodule // pdt_timer
